//--- core/pwa_waveform_gen.sv
// Six-channel waveform action generator with output mask and registers.
// Assumes the period counter lives outside on the same clock and gives its
// value, direction and a one-cycle tick whenever it takes a new value.
//
// Functional notes
// RQ1: Action code 00 keeps the output, 01 drives low, 10 high, 11 toggles.
// RQ2: Register 0xB0 bits [11:0] hold the zero-event code per channel.
// RQ3: Register 0xB0 bits [27:16] hold the period-event code per channel.
// RQ4: In up-down counting the period-event code acts at the centre point.
// RQ5: Register 0xB4 bits [11:0] hold the compare-up code per channel.
// RQ6: Register 0xB4 bits [27:16] hold the compare-down code per channel.
// RQ7: In complementary mode odd compare-down codes serve the even partner.
// RQ8: In complementary mode odd compare-up codes serve the even partner.
// RQ9: A set mask-enable bit replaces the channel output by its mask level.
// RQ10: A clear mask-enable bit passes the generated waveform unchanged.
// RQ11: Both action registers and the mask-enable register reset to zero.
// RQ12: A masked channel drives low for mask level 0 and high for level 1.
// RQ13: Each 16-bit compare value meets the counter; pairs give two points.
// RQ14: Coinciding events for a channel resolve by one fixed priority.
// RQ15: Reserved bits of these registers read as zero and ignore writes.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module pwa_waveform_gen #(
    parameter int CHANNELS = pwa_pkg::PWA_CHANNELS
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [pwa_pkg::PWA_ADDR_W-1:0] i_addr,
    input wire logic [pwa_pkg::PWA_DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [pwa_pkg::PWA_DATA_W-1:0] o_rdata,
    input wire logic [pwa_pkg::PWA_CNT_W-1:0] i_counter_value,
    input wire logic [pwa_pkg::PWA_CNT_W-1:0] i_period_value,
    input wire logic i_count_up,
    input wire logic i_count_tick,
    input wire logic i_updown_mode,
    output logic [pwa_pkg::PWA_CHANNELS-1:0] o_pwm_out
);
    import pwa_pkg::*;

    typedef struct packed {
        logic [PWA_ACT_W-1:0] zero_event_action;
        logic [PWA_ACT_W-1:0] period_event_action;
        logic [PWA_ACT_W-1:0] compare_up_action;
        logic [PWA_ACT_W-1:0] compare_down_action;
        logic [PWA_CHANNELS-1:0] output_mask_on;
        logic [PWA_CHANNELS-1:0] output_mask_level;
        logic [PWA_CHANNELS-1:0][PWA_CNT_W-1:0] compare_value;
        logic complementary;
        logic [PWA_CHANNELS-1:0] wave;
        logic [PWA_CHANNELS-1:0] pwm_out;
        logic [PWA_DATA_W-1:0] rdata;
    } pwa_state_type;

    pwa_state_type state_q;
    pwa_state_type state_d;

    logic zero_hit;
    logic period_hit;
    logic [PWA_CHANNELS-1:0] cmp_match;
    logic [PWA_CHANNELS-1:0] gen_level;
    logic [PWA_DATA_W-1:0] read_value;
    logic [PWA_ADDR_W-1:0] cmp_offset;
    logic [PWA_ADDR_W-3:0] cmp_index;
    logic cmp_window;

    // Counter events are qualified by the tick so that a counter held by
    // a prescaler does not fire the same action on every clock.
    always_comb begin
        zero_hit = i_count_tick && (i_counter_value == PWA_ZERO_COUNT);
        // The tick that brings the count to the period value marks the wrap;
        // in up-down counting the same value is the centre.
        period_hit = i_count_tick
            && (i_counter_value == i_period_value) // RQ3 RQ4
            && (!i_updown_mode || i_count_up); // RQ4
        for (int n = 0; n < PWA_CHANNELS; n++) begin
            cmp_match[n] = i_count_tick
                && (i_counter_value == state_q.compare_value[n]); // RQ13
        end
    end

    genvar g;
    generate
        for (g = 0; g < PWA_CHANNELS; g++) begin : g_chan
            logic cmp1_hit;
            logic [1:0] cmp1_code;
            logic cmp2_hit;
            logic [1:0] cmp2_code;

            // First compare point: the channel's own value and codes
            assign cmp1_hit = cmp_match[g];
            assign cmp1_code = i_count_up
                ? state_q.compare_up_action[2*g +: 2] // RQ5
                : state_q.compare_down_action[2*g +: 2]; // RQ6

            if ((g % 2) == 0) begin : g_even
                // Second compare point borrows the odd partner's value and
                // codes while the pair runs complementary.
                assign cmp2_hit = state_q.complementary
                    && cmp_match[g+1]; // RQ13
                assign cmp2_code = i_count_up
                    ? state_q.compare_up_action[2*(g+1) +: 2] // RQ8
                    : state_q.compare_down_action[2*(g+1) +: 2]; // RQ7
            end else begin : g_odd
                assign cmp2_hit = 1'b0;
                assign cmp2_code = PWA_ACT_NONE;
            end

            pwa_action_gen u_action (
                .i_level(state_q.wave[g]),
                .i_zero_hit(zero_hit),
                .i_zero_code(state_q.zero_event_action[2*g +: 2]), // RQ2
                .i_period_hit(period_hit),
                .i_period_code(state_q.period_event_action[2*g +: 2]), // RQ3
                .i_cmp1_hit(cmp1_hit),
                .i_cmp1_code(cmp1_code),
                .i_cmp2_hit(cmp2_hit),
                .i_cmp2_code(cmp2_code),
                .o_level(gen_level[g])
            );
        end
    endgenerate

    // Compare registers sit at a fixed stride from the first one
    always_comb begin
        cmp_offset = i_addr - PWA_OFS_COMPARE0;
        cmp_index = cmp_offset[PWA_ADDR_W-1:2];
        cmp_window = (i_addr >= PWA_OFS_COMPARE0)
            && (cmp_offset[1:0] == 2'h0)
            && (cmp_index < (PWA_ADDR_W-2)'(PWA_CHANNELS));
    end

    // Read decode; unmapped addresses and reserved bits return zero
    always_comb begin
        read_value = '0;
        case (i_addr)
            PWA_OFS_MODE: begin
                read_value[PWA_COMPL_BIT] = state_q.complementary;
            end
            PWA_OFS_ACT_ZERO_PERIOD: begin
                read_value[PWA_ZERO_LSB +: PWA_ACT_W] =
                    state_q.zero_event_action; // RQ15
                read_value[PWA_PERIOD_LSB +: PWA_ACT_W] =
                    state_q.period_event_action; // RQ15
            end
            PWA_OFS_ACT_COMPARE: begin
                read_value[PWA_CMPU_LSB +: PWA_ACT_W] =
                    state_q.compare_up_action; // RQ15
                read_value[PWA_CMPD_LSB +: PWA_ACT_W] =
                    state_q.compare_down_action; // RQ15
            end
            PWA_OFS_MASK_ENABLE: begin
                read_value[PWA_MASK_LSB +: PWA_CHANNELS] =
                    state_q.output_mask_on; // RQ15
            end
            PWA_OFS_MASK_LEVEL: begin
                read_value[PWA_MASK_LSB +: PWA_CHANNELS] =
                    state_q.output_mask_level;
            end
            PWA_OFS_WAVE_STATUS: begin
                read_value[PWA_CHANNELS-1:0] = state_q.wave;
                read_value[PWA_CHANNELS + PWA_CHANNELS - 1:PWA_CHANNELS] =
                    state_q.pwm_out;
            end
            default: begin
                if (cmp_window) begin
                    read_value[PWA_CNT_W-1:0] =
                        state_q.compare_value[cmp_index];
                end
            end
        endcase
    end

    always_comb begin
        state_d = state_q;

        // Register writes keep only defined fields
        if (i_wr) begin
            case (i_addr)
                PWA_OFS_MODE: begin
                    state_d.complementary = i_wdata[PWA_COMPL_BIT];
                end
                PWA_OFS_ACT_ZERO_PERIOD: begin
                    state_d.zero_event_action =
                        i_wdata[PWA_ZERO_LSB +: PWA_ACT_W]; // RQ2
                    state_d.period_event_action =
                        i_wdata[PWA_PERIOD_LSB +: PWA_ACT_W]; // RQ3
                end
                PWA_OFS_ACT_COMPARE: begin
                    state_d.compare_up_action =
                        i_wdata[PWA_CMPU_LSB +: PWA_ACT_W]; // RQ5
                    state_d.compare_down_action =
                        i_wdata[PWA_CMPD_LSB +: PWA_ACT_W]; // RQ6
                end
                PWA_OFS_MASK_ENABLE: begin
                    state_d.output_mask_on =
                        i_wdata[PWA_MASK_LSB +: PWA_CHANNELS]; // RQ9
                end
                PWA_OFS_MASK_LEVEL: begin
                    state_d.output_mask_level =
                        i_wdata[PWA_MASK_LSB +: PWA_CHANNELS]; // RQ12
                end
                default: begin
                    if (cmp_window) begin
                        state_d.compare_value[cmp_index] =
                            i_wdata[PWA_CNT_W-1:0]; // RQ13
                    end
                end
            endcase
        end

        // Waveform update; an odd channel in a complementary pair inverts
        // its even partner so the two waves never hold the same level.
        for (int n = 0; n < PWA_CHANNELS; n++) begin
            if (state_q.complementary && (n % 2) == 1) begin
                state_d.wave[n] = ~gen_level[n ^ 1]; // RQ7 RQ8
            end else begin
                state_d.wave[n] = gen_level[n];
            end
        end

        // Mask stage sits after the action generator; the mask applies
        // from the same edge as the waveform so no stale level leaks out.
        for (int n = 0; n < PWA_CHANNELS; n++) begin
            if (state_d.output_mask_on[n]) begin
                state_d.pwm_out[n] = state_d.output_mask_level[n]; // RQ9 RQ12
            end else begin
                state_d.pwm_out[n] = state_d.wave[n]; // RQ10
            end
        end

        // Read data stands only in the cycle after the strobe
        state_d.rdata = i_rd ? read_value : '0;
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_q <= '0; // RQ11
        end else begin
            state_q <= state_d;
        end
    end

    assign o_rdata = state_q.rdata;
    assign o_pwm_out = state_q.pwm_out;

endmodule // pwa_waveform_gen

//--- core/pwa_pkg.sv
// Constants for the six-channel waveform action and mask block.
// Assumes a 32-bit register port with byte addresses below 0x100.
package pwa_pkg;

    localparam int PWA_CHANNELS = 6;
    localparam int PWA_CNT_W = 16;
    localparam int PWA_ADDR_W = 8;
    localparam int PWA_DATA_W = 32;
    localparam int PWA_ACT_W = 2 * PWA_CHANNELS;

    // Byte offsets of the registers
    localparam logic [7:0] PWA_OFS_MODE = 8'h00;
    localparam logic [7:0] PWA_OFS_COMPARE0 = 8'h50;
    localparam logic [7:0] PWA_OFS_ACT_ZERO_PERIOD = 8'hB0;
    localparam logic [7:0] PWA_OFS_ACT_COMPARE = 8'hB4;
    localparam logic [7:0] PWA_OFS_MASK_ENABLE = 8'hB8;
    localparam logic [7:0] PWA_OFS_MASK_LEVEL = 8'hBC;
    localparam logic [7:0] PWA_OFS_WAVE_STATUS = 8'hC4;
    localparam logic [7:0] PWA_COMPARE_STRIDE = 8'h04;

    // Field positions
    localparam int PWA_ZERO_LSB = 0;
    localparam int PWA_PERIOD_LSB = 16;
    localparam int PWA_CMPU_LSB = 0;
    localparam int PWA_CMPD_LSB = 16;
    localparam int PWA_MASK_LSB = 0;
    localparam int PWA_COMPL_BIT = 0;

    // Values after reset, and the counter value of the zero event
    localparam logic [PWA_ACT_W-1:0] PWA_ACT_RESET = 12'h000;
    localparam logic [5:0] PWA_MASK_RESET = 6'h00;
    localparam logic [15:0] PWA_COMPARE_RESET = 16'h0000;
    localparam logic [15:0] PWA_ZERO_COUNT = 16'h0000;

    // Action codes
    localparam logic [1:0] PWA_ACT_NONE = 2'h0;
    localparam logic [1:0] PWA_ACT_LOW = 2'h1;
    localparam logic [1:0] PWA_ACT_HIGH = 2'h2;
    localparam logic [1:0] PWA_ACT_TOGGLE = 2'h3;

endpackage

//--- core/pwa_action_gen.sv
// One channel's action resolver: picks the winning event and applies its
// code to the present level. Purely combinational, same clock as caller.
`timescale 1ns/1ps
module pwa_action_gen (
    input wire logic i_level,
    input wire logic i_zero_hit,
    input wire logic [1:0] i_zero_code,
    input wire logic i_period_hit,
    input wire logic [1:0] i_period_code,
    input wire logic i_cmp1_hit,
    input wire logic [1:0] i_cmp1_code,
    input wire logic i_cmp2_hit,
    input wire logic [1:0] i_cmp2_code,
    output logic o_level
);
    import pwa_pkg::*;

    function automatic logic apply_code(input logic lvl,
                                        input logic [1:0] code);
        logic r;
        r = lvl;
        case (code)
            PWA_ACT_NONE: r = lvl; // RQ1
            PWA_ACT_LOW: r = 1'b0; // RQ1
            PWA_ACT_HIGH: r = 1'b1; // RQ1
            PWA_ACT_TOGGLE: r = ~lvl; // RQ1
            default: r = lvl;
        endcase
        return r;
    endfunction

    // Only events carrying a non-zero code compete, so an idle code never
    // hides a lower event; zero beats period beats first and second compare.
    always_comb begin
        if (i_zero_hit && i_zero_code != PWA_ACT_NONE) begin
            o_level = apply_code(i_level, i_zero_code); // RQ14
        end else if (i_period_hit && i_period_code != PWA_ACT_NONE) begin
            o_level = apply_code(i_level, i_period_code); // RQ14
        end else if (i_cmp1_hit && i_cmp1_code != PWA_ACT_NONE) begin
            o_level = apply_code(i_level, i_cmp1_code); // RQ14
        end else if (i_cmp2_hit && i_cmp2_code != PWA_ACT_NONE) begin
            o_level = apply_code(i_level, i_cmp2_code); // RQ14
        end else begin
            o_level = i_level;
        end
    end

endmodule // pwa_action_gen

//--- tb/pwa_load_model.sv
// Load on the six channel pins: records the level seen on every clock.
// Assumes the pins are always driven, so no released level is modelled.
`timescale 1ns/1ps
module pwa_load_model (
    input wire logic i_clk,
    input wire logic [pwa_pkg::PWA_CHANNELS-1:0] i_pins,
    output logic [pwa_pkg::PWA_CHANNELS-1:0] o_seen
);
    import pwa_pkg::*;
    always_ff @(posedge i_clk) begin
        o_seen <= i_pins;
    end
endmodule // pwa_load_model

//--- tb/pwa_waveform_gen_sva.sv
// Assertion checker for the waveform action and mask block.
// Assumes it is bound to pwa_waveform_gen and sees only its ports.
`timescale 1ns/1ps
module pwa_waveform_gen_chk (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [pwa_pkg::PWA_ADDR_W-1:0] i_addr,
    input wire logic [pwa_pkg::PWA_DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [pwa_pkg::PWA_DATA_W-1:0] o_rdata,
    input wire logic [pwa_pkg::PWA_CNT_W-1:0] i_counter_value,
    input wire logic [pwa_pkg::PWA_CNT_W-1:0] i_period_value,
    input wire logic i_count_up,
    input wire logic i_count_tick,
    input wire logic i_updown_mode,
    input wire logic [pwa_pkg::PWA_CHANNELS-1:0] o_pwm_out
);
    import pwa_pkg::*;
    logic [31:0] sh0_q;
    logic [31:0] sh4_q;
    logic [5:0] men_q;
    logic [5:0] mlv_q;
    // Shadows move on the same edge as the registered pins and the mask
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            sh0_q <= 32'h0;
            sh4_q <= 32'h0;
            men_q <= 6'h0;
            mlv_q <= 6'h0;
        end else if (i_wr) begin
            case (i_addr)
                PWA_OFS_ACT_ZERO_PERIOD: sh0_q <= i_wdata & 32'h0FFF0FFF;
                PWA_OFS_ACT_COMPARE: sh4_q <= i_wdata & 32'h0FFF0FFF;
                PWA_OFS_MASK_ENABLE: men_q <= i_wdata[5:0];
                PWA_OFS_MASK_LEVEL: mlv_q <= i_wdata[5:0];
                default: ;
            endcase
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    property p_rd_wg0;
        i_rd && i_addr == PWA_OFS_ACT_ZERO_PERIOD |=> o_rdata == $past(sh0_q);
    endproperty
    a_rd_wg0: assert property (p_rd_wg0)
        else $error("zero/period register readback wrong");
    property p_rd_wg1;
        i_rd && i_addr == PWA_OFS_ACT_COMPARE |=> o_rdata == $past(sh4_q);
    endproperty
    a_rd_wg1: assert property (p_rd_wg1)
        else $error("compare action register readback wrong");
    property p_mask;
        (o_pwm_out & men_q) == (mlv_q & men_q);
    endproperty
    a_mask: assert property (p_mask)
        else $error("masked pin does not show mask level");
    property p_reset;
        $fell(i_sys_rst) |-> o_pwm_out == 6'h00 && o_rdata == 32'h0;
    endproperty
    a_reset: assert property (p_reset)
        else $error("outputs not zero after reset");
    property p_hold;
        !i_count_tick && !i_wr && !$past(i_wr) |=> $stable(o_pwm_out);
    endproperty
    a_hold: assert property (p_hold)
        else $error("pins moved without event or write");
    property p_zero;
        i_count_tick && i_counter_value == 16'h0000 && (sh0_q[1] ^ sh0_q[0])
            |=> o_pwm_out[0] == $past(sh0_q[1]) || men_q[0];
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero event level wrong");
    property p_period;
        i_count_tick && i_counter_value == i_period_value
            && i_counter_value != 16'h0000
            && (i_count_up || !i_updown_mode) && (sh0_q[17] ^ sh0_q[16])
            |=> o_pwm_out[0] == $past(sh0_q[17]) || men_q[0];
    endproperty
    a_period: assert property (p_period)
        else $error("period event level wrong");
    property p_toggle;
        i_count_tick && i_counter_value == 16'h0000 && !men_q[0]
            && sh0_q[1:0] == PWA_ACT_TOGGLE
            && !(i_wr && i_addr == PWA_OFS_MASK_ENABLE)
            |=> o_pwm_out[0] != $past(o_pwm_out[0]);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("toggle did not invert the pin");
endmodule // pwa_waveform_gen_chk

bind pwa_waveform_gen pwa_waveform_gen_chk pwa_waveform_gen_chk_i (
    .i_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_counter_value, .i_period_value, .i_count_up, .i_count_tick,
    .i_updown_mode, .o_pwm_out);

//--- tb/test_pwm_waveform_action_and_mask.sv
// Self-checking bench for the waveform action and mask block.
// Assumes the checker is bound in and the load model sits on the pins.
`timescale 1ns/1ps
module test_pwm_waveform_action_and_mask;
    import pwa_pkg::*;
    logic i_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [31:0] rdata;
    logic [15:0] cnt = 16'h0000;
    logic [15:0] prd = 16'h000A;
    logic up = 1'b1;
    logic tk = 1'b0;
    logic udm = 1'b0;
    logic [5:0] pins;
    logic [5:0] seen;
    logic [5:0] exp_pins = 6'h00;
    logic [1:0] codes [5] = '{2'h2, 2'h0, 2'h1, 2'h3, 2'h3};
    int fail_count = 0;
    int samples_checked = 0;
    pwa_waveform_gen pwa_waveform_gen_i (.i_clk(i_clk), .i_sys_rst(rst),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr_en), .i_rd(rd_en),
        .o_rdata(rdata), .i_counter_value(cnt), .i_period_value(prd),
        .i_count_up(up), .i_count_tick(tk), .i_updown_mode(udm),
        .o_pwm_out(pins));
    pwa_load_model pwa_load_model_i (.i_clk(i_clk), .i_pins(pins),
        .o_seen(seen));
    function automatic logic [5:0] act(input logic [1:0] c,
                                       input logic [5:0] l);
        case (c)
            PWA_ACT_LOW: return 6'h00;
            PWA_ACT_HIGH: return 6'h3F;
            PWA_ACT_TOGGLE: return ~l;
            default: return l;
        endcase
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge i_clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge i_clk);
        rd_en <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    task automatic pin_chk(input logic [5:0] exp);
        @(posedge i_clk);
        #1;
        chk({26'h0, pins}, {26'h0, exp});
    endtask
    // One-cycle tick with a new counter value and direction
    task automatic tick(input logic [15:0] c, input logic u);
        @(posedge i_clk);
        cnt <= c;
        up <= u;
        tk <= 1'b1;
        @(posedge i_clk);
        tk <= 1'b0;
    endtask
    task automatic wrap_up;
        if (fail_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        forever #25 i_clk = ~i_clk;
    end
    initial begin
        #200000;
        fail_count++;
        wrap_up();
    end
    initial begin
        repeat (12) @(posedge i_clk);
        rst <= 1'b0;
        rd_chk(PWA_OFS_ACT_ZERO_PERIOD, 32'h0);
        rd_chk(PWA_OFS_ACT_COMPARE, 32'h0);
        rd_chk(PWA_OFS_MASK_ENABLE, 32'h0);
        pin_chk(6'h00);
        wr(PWA_OFS_ACT_ZERO_PERIOD, 32'hFFFFFFFF);
        rd_chk(PWA_OFS_ACT_ZERO_PERIOD, 32'h0FFF0FFF);
        wr(PWA_OFS_ACT_COMPARE, 32'hFFFFFFFF);
        rd_chk(PWA_OFS_ACT_COMPARE, 32'h0FFF0FFF);
        wr(PWA_OFS_MASK_ENABLE, 32'hFFFFFFC0);
        rd_chk(PWA_OFS_MASK_ENABLE, 32'h0);
        rd_chk(8'hFC, 32'h0);
        wr(PWA_OFS_ACT_COMPARE, 32'h0);
        for (int i = 0; i < 5; i++) begin
            wr(PWA_OFS_ACT_ZERO_PERIOD, {20'h0, {6{codes[i]}}});
            tick(16'h0000, 1'b1);
            exp_pins = act(codes[i], exp_pins);
            pin_chk(exp_pins);
        end
        wr(PWA_OFS_ACT_ZERO_PERIOD, 32'h0AAA0000);
        tick(16'h000A, 1'b1);
        pin_chk(6'h3F);
        wr(PWA_OFS_ACT_ZERO_PERIOD, 32'h05550000);
        udm <= 1'b1;
        tick(16'h000A, 1'b0);
        pin_chk(6'h3F);
        tick(16'h000A, 1'b1);
        pin_chk(6'h00);
        for (int n = 0; n < 6; n++)
            wr(PWA_OFS_COMPARE0 + 8'(4 * n), 32'h5);
        rd_chk(PWA_OFS_COMPARE0 + 8'h14, 32'h5);
        wr(PWA_OFS_ACT_ZERO_PERIOD, 32'h0);
        wr(PWA_OFS_ACT_COMPARE, 32'h05550AAA);
        tick(16'h0005, 1'b1);
        pin_chk(6'h3F);
        tick(16'h0005, 1'b0);
        pin_chk(6'h00);
        wr(PWA_OFS_COMPARE0 + 8'h04, 32'h7);
        wr(PWA_OFS_ACT_COMPARE, 32'h00040008);
        wr(PWA_OFS_MODE, 32'h1);
        rd_chk(PWA_OFS_MODE, 32'h1);
        tick(16'h0007, 1'b1);
        pin_chk(6'h29);
        tick(16'h0007, 1'b0);
        pin_chk(6'h2A);
        wr(PWA_OFS_MODE, 32'h0);
        for (int n = 0; n < 6; n++)
            wr(PWA_OFS_COMPARE0 + 8'(4 * n), 32'h0);
        wr(PWA_OFS_ACT_ZERO_PERIOD, 32'h0AAA0555);
        wr(PWA_OFS_ACT_COMPARE, 32'h00000AAA);
        tick(16'h000A, 1'b1);
        pin_chk(6'h3F);
        tick(16'h0000, 1'b1);
        pin_chk(6'h00);
        wr(PWA_OFS_MASK_ENABLE, 32'h3F);
        wr(PWA_OFS_MASK_LEVEL, 32'hFFFFFF15);
        pin_chk(6'h15);
        rd_chk(PWA_OFS_MASK_LEVEL, 32'h15);
        wr(PWA_OFS_ACT_ZERO_PERIOD, 32'h00000AAA);
        tick(16'h0000, 1'b1);
        pin_chk(6'h15);
        wr(PWA_OFS_MASK_ENABLE, 32'h0);
        pin_chk(6'h3F);
        @(posedge i_clk);
        #1;
        chk({26'h0, seen}, 32'h3F);
        rd_chk(PWA_OFS_WAVE_STATUS, 32'hFFF);
        // Mid-run reset must clear registers and pins again
        @(posedge i_clk);
        rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        rst <= 1'b0;
        rd_chk(PWA_OFS_ACT_ZERO_PERIOD, 32'h0);
        pin_chk(6'h00);
        wrap_up();
    end
endmodule // test_pwm_waveform_action_and_mask
